// ===== hdl/pbm_port_top.v
// bidirectional port and input-only port with apb register access
// assumes pins and timer/converter signals are synchronous to mclk
`include "pbm_consts.vh"

module pbm_port_top
(
    input wire mclk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [7:0] bidir_pin_in,
    output wire [7:0] bidir_pin_out,
    output wire [7:0] bidir_pin_oe,
    input wire [7:0] input_pin_in,
    input wire pwm_b_out,
    input wire pwm_c_out,
    input wire pwm_d_out,
    input wire cmp_a_out,
    input wire cmp_b_out,
    input wire cmp_c_out,
    input wire cmp_d_out,
    output wire timer_ext_count_clock,
    output wire [7:0] timer_capture_in
);

    // ****************************************
    // reset synchroniser
    // ****************************************
    reg rst_meta_n;
    reg rst_sync_n;

    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    reg [7:0] bidir_port_output_latch;
    reg [7:0] bidir_port_direction;
    reg [7:0] timer_mode_reg;
    reg [7:0] timer_io_ctrl_high;
    reg [7:0] timer_io_ctrl_low;
    reg [7:0] analog_select;
    reg [31:0] rdata;

    wire wr_acc = psel && penable && pwrite;
    wire rd_acc = psel && penable && !pwrite;
    wire rd_setup = psel && !penable && !pwrite;

    // ****************************************
    // address decode
    // ****************************************
    localparam SEL_NONE = 3'h0;
    localparam SEL_LATCH = 3'h1;
    localparam SEL_DIR = 3'h2;
    localparam SEL_INPUT = 3'h3;
    localparam SEL_TMODE = 3'h4;
    localparam SEL_TIO_HIGH = 3'h5;
    localparam SEL_TIO_LOW = 3'h6;
    localparam SEL_ANALOG = 3'h7;

    // unmapped byte addresses give the none index
    function [2:0] reg_sel;
        input [11:0] a;
        begin
            case (a)
                `PBM_OFF_LATCH: reg_sel = SEL_LATCH;
                `PBM_OFF_DIR: reg_sel = SEL_DIR;
                `PBM_OFF_INPUT: reg_sel = SEL_INPUT;
                `PBM_OFF_TMODE: reg_sel = SEL_TMODE;
                `PBM_OFF_TIO_HIGH: reg_sel = SEL_TIO_HIGH;
                `PBM_OFF_TIO_LOW: reg_sel = SEL_TIO_LOW;
                `PBM_OFF_ANALOG: reg_sel = SEL_ANALOG;
                default: reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    wire [2:0] acc_sel = reg_sel(paddr);
    wire acc_known = (acc_sel != SEL_NONE);

    // the input port index has no write strobe
    wire wr_latch = wr_acc && (acc_sel == SEL_LATCH);
    wire wr_dir = wr_acc && (acc_sel == SEL_DIR);
    wire wr_tmode = wr_acc && (acc_sel == SEL_TMODE);
    wire wr_tio_high = wr_acc && (acc_sel == SEL_TIO_HIGH);
    wire wr_tio_low = wr_acc && (acc_sel == SEL_TIO_LOW);
    wire wr_analog = wr_acc && (acc_sel == SEL_ANALOG);

    // ****************************************
    // register updates
    // ****************************************
    always @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            bidir_port_output_latch <= `PBM_RST_LATCH;
        else if (wr_latch)
            bidir_port_output_latch <= pwdata[7:0];
    end

    always @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            bidir_port_direction <= `PBM_RST_DIR;
        else if (wr_dir)
            bidir_port_direction <= pwdata[7:0];
    end

    always @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            timer_mode_reg <= `PBM_RST_TMODE;
        else if (wr_tmode)
            timer_mode_reg <= pwdata[7:0];
    end

    always @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            timer_io_ctrl_high <= `PBM_RST_TIO;
        else if (wr_tio_high)
            timer_io_ctrl_high <= pwdata[7:0];
    end

    always @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            timer_io_ctrl_low <= `PBM_RST_TIO;
        else if (wr_tio_low)
            timer_io_ctrl_low <= pwdata[7:0];
    end

    always @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            analog_select <= `PBM_RST_ANALOG;
        else if (wr_analog)
            analog_select <= pwdata[7:0];
    end

    // ****************************************
    // read data
    // ****************************************
    // direction one reads latch, zero reads pin
    wire [7:0] bidir_read = (bidir_port_output_latch & bidir_port_direction) |
        (bidir_pin_in & ~bidir_port_direction);
    wire [7:0] input_port_pin_sample = input_pin_in & ~analog_select;

    // read data is a flop loaded in the setup cycle; latch reads are sampled there too
    always @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            rdata <= 32'h0000_0000;
        else if (rd_setup)
        begin
            case (paddr)
                `PBM_OFF_LATCH: rdata <= {24'h00_0000, bidir_read};
                `PBM_OFF_DIR: rdata <= {24'h00_0000, bidir_port_direction};
                `PBM_OFF_INPUT: rdata <= {24'h00_0000, input_port_pin_sample};
                `PBM_OFF_TMODE: rdata <= {24'h00_0000, timer_mode_reg};
                `PBM_OFF_TIO_HIGH: rdata <= {24'h00_0000, timer_io_ctrl_high};
                `PBM_OFF_TIO_LOW: rdata <= {24'h00_0000, timer_io_ctrl_low};
                `PBM_OFF_ANALOG: rdata <= {24'h00_0000, analog_select};
                default: rdata <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = rdata;
    assign pready = 1'b1;
    assign pslverr = (wr_acc || rd_acc) && !acc_known;

    // ****************************************
    // pin muxing
    // ****************************************
    wire [2:0] chan_a_io_select = timer_io_ctrl_low[`PBM_IO_LO_LSB +: 3];
    wire [2:0] chan_b_io_select = timer_io_ctrl_low[`PBM_IO_HI_LSB +: 3];
    wire [2:0] chan_c_io_select = timer_io_ctrl_high[`PBM_IO_LO_LSB +: 3];
    wire [2:0] chan_d_io_select = timer_io_ctrl_high[`PBM_IO_HI_LSB +: 3];
    wire chan_b_pwm_mode = timer_mode_reg[`PBM_PWM_B_BIT];
    wire chan_c_pwm_mode = timer_mode_reg[`PBM_PWM_C_BIT];
    wire chan_d_pwm_mode = timer_mode_reg[`PBM_PWM_D_BIT];

    // timer claims override the direction bit
    pbm_pin_select u_pin4 (
        .has_pwm(1'b1),
        .pwm_mode(chan_d_pwm_mode),
        .io_select(chan_d_io_select),
        .dir(bidir_port_direction[4]),
        .latch(bidir_port_output_latch[4]),
        .pwm_out(pwm_d_out),
        .cmp_out(cmp_d_out),
        .pin_out(bidir_pin_out[4]),
        .pin_oe(bidir_pin_oe[4])
    );

    pbm_pin_select u_pin3 (
        .has_pwm(1'b1),
        .pwm_mode(chan_c_pwm_mode),
        .io_select(chan_c_io_select),
        .dir(bidir_port_direction[3]),
        .latch(bidir_port_output_latch[3]),
        .pwm_out(pwm_c_out),
        .cmp_out(cmp_c_out),
        .pin_out(bidir_pin_out[3]),
        .pin_oe(bidir_pin_oe[3])
    );

    pbm_pin_select u_pin2 (
        .has_pwm(1'b1),
        .pwm_mode(chan_b_pwm_mode),
        .io_select(chan_b_io_select),
        .dir(bidir_port_direction[2]),
        .latch(bidir_port_output_latch[2]),
        .pwm_out(pwm_b_out),
        .cmp_out(cmp_b_out),
        .pin_out(bidir_pin_out[2]),
        .pin_oe(bidir_pin_oe[2])
    );

    pbm_pin_select u_pin1 (
        .has_pwm(1'b0),
        .pwm_mode(1'b0),
        .io_select(chan_a_io_select),
        .dir(bidir_port_direction[1]),
        .latch(bidir_port_output_latch[1]),
        .pwm_out(1'b0),
        .cmp_out(cmp_a_out),
        .pin_out(bidir_pin_out[1]),
        .pin_oe(bidir_pin_oe[1])
    );

    // ****************************************
    // plain general io pins
    // ****************************************
    // no timer output here: the io code is tied to the no claim value
    pbm_pin_select u_pin7 (
        .has_pwm(1'b0),
        .pwm_mode(1'b0),
        .io_select(3'h0),
        .dir(bidir_port_direction[7]),
        .latch(bidir_port_output_latch[7]),
        .pwm_out(1'b0),
        .cmp_out(1'b0),
        .pin_out(bidir_pin_out[7]),
        .pin_oe(bidir_pin_oe[7])
    );

    pbm_pin_select u_pin6 (
        .has_pwm(1'b0),
        .pwm_mode(1'b0),
        .io_select(3'h0),
        .dir(bidir_port_direction[6]),
        .latch(bidir_port_output_latch[6]),
        .pwm_out(1'b0),
        .cmp_out(1'b0),
        .pin_out(bidir_pin_out[6]),
        .pin_oe(bidir_pin_oe[6])
    );

    pbm_pin_select u_pin5 (
        .has_pwm(1'b0),
        .pwm_mode(1'b0),
        .io_select(3'h0),
        .dir(bidir_port_direction[5]),
        .latch(bidir_port_output_latch[5]),
        .pwm_out(1'b0),
        .cmp_out(1'b0),
        .pin_out(bidir_pin_out[5]),
        .pin_oe(bidir_pin_oe[5])
    );

    pbm_pin_select u_pin0 (
        .has_pwm(1'b0),
        .pwm_mode(1'b0),
        .io_select(3'h0),
        .dir(bidir_port_direction[0]),
        .latch(bidir_port_output_latch[0]),
        .pwm_out(1'b0),
        .cmp_out(1'b0),
        .pin_out(bidir_pin_out[0]),
        .pin_oe(bidir_pin_oe[0])
    );

    // ****************************************
    // timer inputs
    // ****************************************
    // capture inputs and count clock always see the pin level
    assign timer_ext_count_clock = bidir_pin_in[0];
    assign timer_capture_in = bidir_pin_in;

endmodule

// ===== hdl/pbm_consts.vh
// register offsets, field positions and reset values for the port block
// assumes the apb slave in pbm_port_top decodes word aligned byte addresses
//
// How it works
// - 8-bit output latch, cpu read/write, resets zero
// - direction one: data read returns latch
// - direction zero: data read returns pin
// - direction one drives pin, zero is input
// - pin 4: pwm, compare, or general io
// - pin 3 uses channel c the same way
// - pin 2 uses channel b the same way
// - pin 1: compare or general io, no pwm
// - pin 0 general io, always feeds count clock
// - timer output claim beats direction bit
// - input port register read only, no reset
// - input port read returns pin levels
// - analog selected input pins read zero
`ifndef PBM_CONSTS_VH
`define PBM_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define PBM_OFF_LATCH 12'h000
`define PBM_OFF_DIR 12'h004
`define PBM_OFF_INPUT 12'h008
`define PBM_OFF_TMODE 12'h00C
`define PBM_OFF_TIO_HIGH 12'h010
`define PBM_OFF_TIO_LOW 12'h014
`define PBM_OFF_ANALOG 12'h018

// ****************************************
// field positions
// ****************************************
`define PBM_PWM_B_BIT 0
`define PBM_PWM_C_BIT 1
`define PBM_PWM_D_BIT 2
`define PBM_IO_LO_LSB 0
`define PBM_IO_HI_LSB 4

// ****************************************
// reset values
// ****************************************
`define PBM_RST_LATCH 8'h00
`define PBM_RST_DIR 8'h00
`define PBM_RST_TMODE 8'h00
`define PBM_RST_TIO 8'h00
`define PBM_RST_ANALOG 8'h00

`endif

// ===== hdl/pbm_pin_select.v
// one timer shared pin: chooses between pwm, compare and general io
// assumes timer outputs are synchronous to mclk

module pbm_pin_select
(
    input wire has_pwm,
    input wire pwm_mode,
    input wire [2:0] io_select,
    input wire dir,
    input wire latch,
    input wire pwm_out,
    input wire cmp_out,
    output reg pin_out,
    output reg pin_oe
);

    // codes 001 and 01x claim the pin as compare output
    function cmp_claim;
        input [2:0] code;
        begin
            cmp_claim = (code[2] == 1'b0) && (code[1:0] != 2'b00);
        end
    endfunction

    always @*
    begin
        if (has_pwm && pwm_mode)
        begin
            pin_out = pwm_out;
            pin_oe = 1'b1;
        end
        else if (cmp_claim(io_select))
        begin
            pin_out = cmp_out;
            pin_oe = 1'b1;
        end
        else
        begin
            pin_out = latch;
            pin_oe = dir;
        end
    end

endmodule

// ===== testbench/pbm_port_chk.sv
// port block checker, bound to pbm_port_top
// assumes mclk is the only clock and pready stays high
module pbm_port_chk
(
    input logic mclk,
    input logic rstn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic pslverr,
    input logic [7:0] bidir_pin_in,
    input logic [7:0] bidir_pin_out,
    input logic [7:0] bidir_pin_oe,
    input logic cmp_a_out,
    input logic timer_ext_count_clock,
    input logic [7:0] timer_capture_in
);
    timeunit 1ns;
    timeprecision 1ns;
    wire wr = psel && penable && pwrite;
    wire rd0 = psel && !penable && !pwrite && paddr == 12'h000;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    count_clk_a: assert property (timer_ext_count_clock == bidir_pin_in[0])
        else $error("count clock differs from pin 0");
    capture_a: assert property (timer_capture_in == bidir_pin_in)
        else $error("capture inputs differ from pins");
    dir_hold_a: assert property ($changed(bidir_pin_oe) |-> $past(wr))
        else $error("drive enable moved without a write");
    gpio_hi_a: assert property ($changed(bidir_pin_out[7:5]) |-> $past(wr))
        else $error("upper pins moved without a write");
    pin0_gpio_a: assert property ($changed(bidir_pin_out[0]) |-> $past(wr))
        else $error("pin 0 moved without a write");
    pin1_cmp_a: assert property ($changed(bidir_pin_out[1]) && !$past(wr)
        |-> bidir_pin_out[1] == cmp_a_out && bidir_pin_oe[1]) else $error("pin 1 not compare");
    pin7_read_a: assert property (rd0 |=>
        prdata[7] == ($past(bidir_pin_oe[7]) ? $past(bidir_pin_out[7]) : $past(bidir_pin_in[7])))
        else $error("latch read bit 7");
    err_read_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read not zero");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
endmodule
bind pbm_port_top pbm_port_chk u_chk (
    .mclk(mclk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pslverr(pslverr),
    .bidir_pin_in(bidir_pin_in),
    .bidir_pin_out(bidir_pin_out),
    .bidir_pin_oe(bidir_pin_oe),
    .cmp_a_out(cmp_a_out),
    .timer_ext_count_clock(timer_ext_count_clock),
    .timer_capture_in(timer_capture_in)
);

// ===== testbench/pbm_far_side.sv
// pins and timer sources beyond the port block
// assumes the bench sets the outside pin levels
module pbm_far_side
(
    input logic mclk,
    input logic rstn,
    input logic [7:0] ext_lvl,
    input logic [7:0] bidir_pin_out,
    input logic [7:0] bidir_pin_oe,
    output logic [7:0] bidir_pin_in,
    output logic [6:0] tmr_src
);
    timeunit 1ns;
    timeprecision 1ns;
    // a driven pin reads back its own drive
    assign bidir_pin_in = (bidir_pin_oe & bidir_pin_out) | (~bidir_pin_oe & ext_lvl);
    // timer waveforms are counter bits; only bit 0 changes every cycle
    always @(posedge mclk or negedge rstn)
        if (!rstn)
            tmr_src <= 7'h00;
        else
            tmr_src <= tmr_src + 7'h01;
endmodule

// ===== testbench/test_port8_portb_io_mux.sv
// bench for pbm_port_top: apb driver, read queue, pin checks
// assumes pbm_far_side models the pins and timer
`include "pbm_consts.vh"
module test_port8_portb_io_mux;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] ext = 8'h00, inp = 8'h00, rnd = 8'h0F, lat, d, oe;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [7:0] pin_out, pin_oe, pin_in;
    wire [6:0] src;
    logic [32:0] expq[$];
    logic [32:0] exp_word;
    int error_cnt = 0, total_checks = 0;
    always #50 mclk = ~mclk;
    pbm_port_top DUT (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bidir_pin_in(pin_in), .bidir_pin_out(pin_out),
        .bidir_pin_oe(pin_oe), .input_pin_in(inp), .pwm_b_out(src[0]), .pwm_c_out(src[1]),
        .pwm_d_out(src[2]), .cmp_a_out(src[3]), .cmp_b_out(src[4]), .cmp_c_out(src[5]),
        .cmp_d_out(src[6]), .timer_ext_count_clock(), .timer_capture_in());
    pbm_far_side far (.mclk(mclk), .rstn(rstn), .ext_lvl(ext), .bidir_pin_out(pin_out),
        .bidir_pin_oe(pin_oe), .bidir_pin_in(pin_in), .tmr_src(src));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic note(input logic ok, input string m);
        total_checks++;
        if (!ok)
        begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        note(got === exp, "read data");
    endtask
    task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
        note(got === exp, "pin drive");
    endtask
    task automatic cmp_err(input logic got, input logic exp);
        note(got === exp, "slave error");
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
        expq.push_back({err, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic end_of_test;
        if (expq.size() != 0)
            error_cnt++;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ****
    // read monitor
    // ****
    always @(posedge mclk)
        if (psel && penable && !pwrite && pready)
        begin
            exp_word = expq.pop_front();
            cmp_rd(prdata, exp_word[31:0]);
            cmp_err(pslverr, exp_word[32]);
        end
    initial
    begin
        #500000;
        error_cnt++;
        end_of_test;
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        apb(1'b1, `PBM_OFF_DIR, 32'h0000_00FF);
        rd(`PBM_OFF_LATCH, 32'h0000_0000, 1'b0);
        cmp_pin(pin_oe, 8'hFF);
        cmp_pin(pin_out, 8'h00);
        lat = lfsr(rnd);
        apb(1'b1, `PBM_OFF_LATCH, {24'h0, lat});
        for (int i = 0; i < 5; i++)
        begin
            rnd = lfsr(rnd);
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : rnd;
            ext <= {rnd[3:0], rnd[7:4]};
            apb(1'b1, `PBM_OFF_DIR, {24'h0, d});
            rd(`PBM_OFF_LATCH, {24'h0, (d & lat) | (~d & ext)}, 1'b0);
            cmp_pin(pin_oe, d);
            cmp_pin(pin_out & d, lat & d);
        end
        apb(1'b1, `PBM_OFF_DIR, 32'h0000_0000);
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, `PBM_OFF_TIO_HIGH, {24'h0, 1'b0, c[2:0], 1'b0, c[2:0]});
            apb(1'b1, `PBM_OFF_TIO_LOW, {24'h0, 1'b0, c[2:0], 1'b0, c[2:0]});
            @(negedge mclk);
            oe = (c >= 1 && c <= 3) ? 8'h1E : 8'h00;
            cmp_pin(pin_oe, oe);
            cmp_pin(pin_out & oe, {3'b000, src[6:3], 1'b0} & oe);
            cmp_pin(pin_out & ~oe, lat & ~oe);
        end
        apb(1'b1, `PBM_OFF_TMODE, 32'h0000_0007);
        inp <= lfsr(rnd);
        @(negedge mclk);
        cmp_pin(pin_oe, 8'h1C);
        cmp_pin(pin_out & 8'h1C, {3'b000, src[2:0], 2'b00});
        rd(`PBM_OFF_INPUT, {24'h0, inp}, 1'b0);
        apb(1'b1, `PBM_OFF_ANALOG, 32'h0000_000F);
        rd(`PBM_OFF_INPUT, {24'h0, inp & 8'hF0}, 1'b0);
        apb(1'b1, `PBM_OFF_INPUT, 32'h0000_00FF);
        rd(`PBM_OFF_INPUT, {24'h0, inp & 8'hF0}, 1'b0);
        rd(12'h040, 32'h0000_0000, 1'b1);
        repeat (2) @(posedge mclk);
        end_of_test;
    end
endmodule
